/* File: core/osc_pkg.sv */
// Constants for the oscillator selection control block
package osc_pkg;
    localparam logic [7:0]  OSC_CTRL_ADDR    = 8'h00;
    localparam logic [7:0]  OSC_UNLOCK_ADDR  = 8'h04;
    localparam logic [31:0] UNLOCK_KEY_ONE   = 32'haa99_6655;
    localparam logic [31:0] UNLOCK_KEY_TWO   = 32'h5566_99aa;
    localparam int          DIV_LSB          = 24;
    localparam int          MULT_LSB         = 16;
    localparam int          CUR_LSB          = 12;
    localparam int          REQ_LSB          = 8;
    localparam int          LOCK_BIT         = 7;
    localparam int          USB_LOCK_BIT     = 6;
    localparam int          SYS_LOCK_BIT     = 5;
    localparam int          SLEEP_BIT        = 4;
    localparam int          SWITCH_BIT       = 0;
    localparam logic [2:0]  MULT_RESET       = 3'h0;
    localparam logic [2:0]  DIV_RESET        = 3'h0;
    localparam logic [2:0]  SRC_FAST_RC_DIV  = 3'h7;
    localparam logic [2:0]  SWITCH_TIME_NS   = 3'h0;
    localparam int          CLK_PERIOD_NS    = 8;
    localparam int          SWITCH_NS        = 80;
    localparam logic [7:0]  SWITCH_CYCLES    = 8'((SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0]  MON_LOCKABLE_BIT = 2'h2;
endpackage

/* File: core/osc_select_ctrl.sv */
// Oscillator control register, source switch sequencing and lock status
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps

// Operation
// - Multiplier code in bits 18-16 selects a factor of 15,16,17,18,19,20,21 or 24.
// - Bits 14-12 report the clock source currently running.
// - Bits 10-8 hold the requested source in the same encoding.
// - Source code 111 divides the fast RC clock by the ratio in bits 26:24.
// - Every reset loads the requested source from the configuration select field.
// - With monitor config 1x a set lock bit 7 blocks selection changes.
// - With monitor config 0x selections stay writable whatever the lock bit.
// - Bit 6 reads the USB PLL lock or timer-expired status.
// - Bit 5 reads the system PLL lock or timer-expired status.
// - Bit 4 picks sleep when set and idle when clear for the wait instruction.
// - Writes to the control register take effect only as the first control write after an unlock sequence.
// - Bits 15 and 11 always read as zero.
module osc_select_ctrl (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [2:0]  cfg_source_select_in,
    input  wire logic [1:0]  switch_monitor_cfg_in,
    input  wire logic        usb_pll_lock_in,
    input  wire logic        sys_pll_lock_in,
    output logic      [31:0] rdata_out,
    output logic      [4:0]  pll_factor_out,
    output logic      [2:0]  active_source_out,
    output logic      [2:0]  fast_rc_divider_out,
    output logic             sleep_on_wait_out
);
    typedef enum logic [1:0] {
        OSC_IDLE   = 2'b00,
        OSC_SWITCH = 2'b01
    } osc_state_t;

    typedef struct packed {
        osc_state_t  state;
        logic [1:0]  unlock_stage;
        logic [7:0]  sw_count;
        logic [2:0]  pll_multiplier;
        logic [2:0]  fast_rc_divider;
        logic [2:0]  current_source;
        logic [2:0]  requested_source;
        logic        selection_lock;
        logic        sleep_on_wait;
        logic [1:0]  usb_sync;
        logic [1:0]  sys_sync;
        logic [2:0]  cfg_meta;
        logic [2:0]  cfg_sync;
        logic        cfg_load;
        logic [31:0] rdata;
        logic [4:0]  pll_factor;
    } osc_regs_t;

    osc_regs_t s_q;
    osc_regs_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Multiplier decode
    function automatic logic [4:0] osc_mult_factor(input logic [2:0] code);
        logic [4:0] f;
        f = 5'h0f;
        case (code)
            3'h7:    f = 5'h18;
            default: f = 5'(5'h0f + {2'h0, code});
        endcase
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register read image
    function automatic logic [31:0] osc_image(input osc_regs_t s);
        logic [31:0] v;
        v = 32'h0;
        v[osc_pkg::DIV_LSB +: 3]   = s.fast_rc_divider;
        v[osc_pkg::MULT_LSB +: 3]  = s.pll_multiplier;
        v[osc_pkg::CUR_LSB +: 3]   = s.current_source;
        v[osc_pkg::REQ_LSB +: 3]   = s.requested_source;
        v[osc_pkg::LOCK_BIT]       = s.selection_lock;
        v[osc_pkg::USB_LOCK_BIT]   = s.usb_sync[1];
        v[osc_pkg::SYS_LOCK_BIT]   = s.sys_sync[1];
        v[osc_pkg::SLEEP_BIT]      = s.sleep_on_wait;
        v[osc_pkg::SWITCH_BIT]     = (s.state == OSC_SWITCH);
        return v;
    endfunction

    logic frozen;
    logic ctrl_wr;
    logic unlock_wr;

    always_comb begin
        // Lock only matters with monitor config 1x
        frozen    = s_q.selection_lock && switch_monitor_cfg_in[1];
        ctrl_wr   = wr_in && (addr_in == osc_pkg::OSC_CTRL_ADDR);
        unlock_wr = wr_in && (addr_in == osc_pkg::OSC_UNLOCK_ADDR);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.usb_sync = {s_q.usb_sync[0], usb_pll_lock_in};
        s_d.sys_sync = {s_q.sys_sync[0], sys_pll_lock_in};
        s_d.cfg_meta = cfg_source_select_in;
        s_d.cfg_sync = s_q.cfg_meta;
        s_d.cfg_load = 1'b0;
        if (s_q.cfg_load) begin
            s_d.requested_source = s_q.cfg_sync;
            s_d.current_source   = s_q.cfg_sync;
        end
        // Unlock: two key writes in a row, then one control write
        if (unlock_wr) begin
            if (wdata_in == osc_pkg::UNLOCK_KEY_ONE) begin
                s_d.unlock_stage = 2'h1;
            end else if (wdata_in == osc_pkg::UNLOCK_KEY_TWO && s_q.unlock_stage == 2'h1) begin
                s_d.unlock_stage = 2'h2;
            end else begin
                s_d.unlock_stage = 2'h0;
            end
        end else if (ctrl_wr) begin
            s_d.unlock_stage = 2'h0;
            if (s_q.unlock_stage == 2'h2 && !s_q.cfg_load) begin
                s_d.sleep_on_wait = wdata_in[osc_pkg::SLEEP_BIT];
                s_d.selection_lock = wdata_in[osc_pkg::LOCK_BIT];
                if (!frozen) begin
                    s_d.pll_multiplier   = wdata_in[osc_pkg::MULT_LSB +: 3];
                    s_d.fast_rc_divider  = wdata_in[osc_pkg::DIV_LSB +: 3];
                    s_d.requested_source = wdata_in[osc_pkg::REQ_LSB +: 3];
                    if (wdata_in[osc_pkg::SWITCH_BIT] && s_q.state == OSC_IDLE) begin
                        s_d.state    = OSC_SWITCH;
                        s_d.sw_count = osc_pkg::SWITCH_CYCLES;
                    end
                end else begin
                    s_d.selection_lock = 1'b1;
                end
            end
        end
        case (s_q.state)
            OSC_SWITCH: begin
                if (s_q.sw_count <= 8'h1) begin
                    s_d.state          = OSC_IDLE;
                    s_d.current_source = s_q.requested_source;
                    s_d.sw_count       = 8'h0;
                end else begin
                    s_d.sw_count = s_q.sw_count - 8'h1;
                end
            end
            OSC_IDLE: begin
                // A start requested by the write above stands
            end
            default: s_d.state = OSC_IDLE;
        endcase
        s_d.rdata = 32'h0;
        if (rd_in && addr_in == osc_pkg::OSC_CTRL_ADDR) begin
            s_d.rdata = osc_image(s_q);
        end
        s_d.pll_factor = osc_mult_factor(s_d.pll_multiplier);
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q                 <= '0;
            s_q.state           <= OSC_IDLE;
            s_q.pll_multiplier  <= osc_pkg::MULT_RESET;
            s_q.fast_rc_divider <= osc_pkg::DIV_RESET;
            s_q.pll_factor      <= 5'h0f;
            s_q.cfg_load        <= 1'b1;
            // Config select keeps moving through its synchroniser in reset
            s_q.cfg_meta        <= cfg_source_select_in;
            s_q.cfg_sync        <= s_q.cfg_meta;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out           = s_q.rdata;
    assign pll_factor_out      = s_q.pll_factor;
    assign active_source_out   = s_q.current_source;
    assign fast_rc_divider_out = s_q.fast_rc_divider;
    assign sleep_on_wait_out   = s_q.sleep_on_wait;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence unlock_seq;
        unlock_wr && wdata_in == osc_pkg::UNLOCK_KEY_ONE ##1
        unlock_wr && wdata_in == osc_pkg::UNLOCK_KEY_TWO;
    endsequence

    sequence unlocked_ctrl_seq;
        unlock_seq ##1 (ctrl_wr && !s_q.cfg_load);
    endsequence

    sequence open_write_seq;
        unlock_seq ##1 (ctrl_wr && !frozen && !s_q.cfg_load);
    endsequence

    // Ten cycles in the switch state
    sequence switch_busy_seq;
        (s_q.state == OSC_SWITCH)[*8] ##1
        (s_q.state == OSC_SWITCH) ##1 (s_q.state == OSC_SWITCH);
    endsequence

    mult_decode_a: assert property (@(posedge clk_in) disable iff (reset_in)
        s_q.pll_factor == osc_mult_factor(s_q.pll_multiplier))
        else $error("pll factor mismatch");

    cur_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_q.state == OSC_SWITCH && !s_q.cfg_load) |=> $stable(active_source_out)
            || s_q.state == OSC_IDLE)
        else $error("current source moved mid switch");

    locked_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_wr && frozen) |=> $stable(s_q.requested_source) && $stable(s_q.pll_multiplier))
        else $error("locked selection changed");

    open_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (unlock_seq ##1 (ctrl_wr && !switch_monitor_cfg_in[1] && !s_q.cfg_load))
            |=> s_q.requested_source == $past(wdata_in[10:8]))
        else $error("open selection not written");

    no_unlock_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_wr && s_q.unlock_stage != 2'h2) |=> $stable(s_q.sleep_on_wait))
        else $error("write without unlock took effect");

    zero_bits_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rd_in |=> rdata_out[15] == 1'b0 && rdata_out[11] == 1'b0)
        else $error("unimplemented bits not zero");

    switch_done_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(s_q.state == OSC_SWITCH) |-> ##[1:20] active_source_out == s_q.requested_source)
        else $error("switch did not complete");

    sys_lock_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_in && addr_in == osc_pkg::OSC_CTRL_ADDR)
            |=> rdata_out[5] == $past(sys_pll_lock_in, 3))
        else $error("system lock status wrong");

    usb_lock_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_in && addr_in == osc_pkg::OSC_CTRL_ADDR)
            |=> rdata_out[6] == $past(usb_pll_lock_in, 3))
        else $error("usb lock status wrong");

    mult_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        open_write_seq |=> s_q.pll_multiplier == $past(wdata_in[osc_pkg::MULT_LSB +: 3]))
        else $error("multiplier not written");

    factor_top_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_q.pll_multiplier == 3'h7) |-> pll_factor_out == 5'h18)
        else $error("top multiplier code not 24");

    factor_base_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (s_q.pll_multiplier == 3'h0) |-> pll_factor_out == 5'h0f)
        else $error("bottom multiplier code not 15");

    cur_image_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_in && addr_in == osc_pkg::OSC_CTRL_ADDR)
            |=> rdata_out[osc_pkg::CUR_LSB +: 3] == $past(active_source_out))
        else $error("current source image wrong");

    req_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        open_write_seq |=> s_q.requested_source == $past(wdata_in[osc_pkg::REQ_LSB +: 3]))
        else $error("requested source not written");

    div_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        open_write_seq |=> fast_rc_divider_out == $past(wdata_in[osc_pkg::DIV_LSB +: 3]))
        else $error("divider not written");

    reset_req_a: assert property (@(posedge clk_in) disable iff (reset_in)
        s_q.cfg_load |=> s_q.requested_source == $past(cfg_source_select_in, 3))
        else $error("requested source not loaded from config");

    reset_cur_a: assert property (@(posedge clk_in) disable iff (reset_in)
        s_q.cfg_load |=> active_source_out == s_q.requested_source)
        else $error("current source not loaded from config");

    lock_kept_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_wr && frozen) |=> s_q.selection_lock)
        else $error("frozen write released lock");

    locked_div_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_wr && frozen) |=> $stable(fast_rc_divider_out))
        else $error("locked divider changed");

    locked_start_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_wr && frozen && s_q.state == OSC_IDLE) |=> s_q.state == OSC_IDLE)
        else $error("locked write started a switch");

    lock_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        open_write_seq |=> s_q.selection_lock == $past(wdata_in[osc_pkg::LOCK_BIT]))
        else $error("lock bit not written");

    sleep_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
        unlocked_ctrl_seq |=> sleep_on_wait_out == $past(wdata_in[osc_pkg::SLEEP_BIT]))
        else $error("sleep select not written");

    quiet_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !rd_in |=> rdata_out == 32'h0)
        else $error("read data without a read");

    unmapped_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_in && addr_in != osc_pkg::OSC_CTRL_ADDR) |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");

    spare_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_in && addr_in == osc_pkg::OSC_CTRL_ADDR)
            |=> rdata_out[31:27] == 5'h0 && rdata_out[23:19] == 5'h0
            && rdata_out[3:1] == 3'h0)
        else $error("spare bits not zero");

    switch_len_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(s_q.state == OSC_SWITCH) |-> switch_busy_seq ##1 (s_q.state == OSC_IDLE))
        else $error("switch length wrong");

    cur_moves_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !$stable(active_source_out) |-> $past(s_q.state == OSC_SWITCH) || $past(s_q.cfg_load))
        else $error("current source moved outside a switch");

    busy_bit_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (rd_in && addr_in == osc_pkg::OSC_CTRL_ADDR)
            |=> rdata_out[osc_pkg::SWITCH_BIT] == $past(s_q.state == OSC_SWITCH))
        else $error("switch busy bit wrong");
endmodule

/* File: verif/osc_select_ctrl_test.sv */
// Self-checking bench for the oscillator selection control block
`timescale 1ns/1ps
module osc_select_ctrl_test;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        usb_pll_lock_in = 1'b0;
    logic        sys_pll_lock_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic [31:0] rdata_out;
    logic [2:0]  cfg_source_select_in = 3'h2;
    logic [1:0]  switch_monitor_cfg_in = 2'h0;
    logic [4:0]  pll_factor_out;
    logic [2:0]  active_source_out;
    logic [2:0]  fast_rc_divider_out;
    logic        sleep_on_wait_out;
    int          failures = 0;
    int          n_checks = 0;
    int          mult, div, req, cur, lock, slp, i;
    int          fac [8] = '{15, 16, 17, 18, 19, 20, 21, 24};

    osc_select_ctrl dut_u (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .cfg_source_select_in(cfg_source_select_in),
        .switch_monitor_cfg_in(switch_monitor_cfg_in), .usb_pll_lock_in(usb_pll_lock_in),
        .sys_pll_lock_in(sys_pll_lock_in), .rdata_out(rdata_out),
        .pll_factor_out(pll_factor_out), .active_source_out(active_source_out),
        .fast_rc_divider_out(fast_rc_divider_out), .sleep_on_wait_out(sleep_on_wait_out));

    always #4 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Called just after a rising edge; strobe stays up for the next access
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        wr_in    <= w;
        rd_in    <= !w;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_in);
    endtask

    // Read data stand in the following cycle, sampled mid cycle
    task automatic rd_at(logic [7:0] a);
        acc(1'b0, a, 32'h0);
        rd_in <= 1'b0;
        @(negedge clk_in);
    endtask

    function automatic logic [31:0] img();
        img = 32'h0;
        img[26:24] = 3'(div);
        img[18:16] = 3'(mult);
        img[14:12] = 3'(cur);
        img[10:8]  = 3'(req);
        img[7]     = lock[0];
        img[6]     = usb_pll_lock_in;
        img[5]     = sys_pll_lock_in;
        img[4]     = slp[0];
    endfunction

    task automatic look(string n);
        rd_at(osc_pkg::OSC_CTRL_ADDR);
        chk({n, " image"}, rdata_out, img());
        chk({n, " factor"}, 32'(pll_factor_out), 32'(fac[mult]));
        chk({n, " source"}, 32'(active_source_out), 32'(cur));
        chk({n, " divider"}, 32'(fast_rc_divider_out), 32'(div));
        chk({n, " sleep"}, 32'(sleep_on_wait_out), 32'(slp));
        $display("test %s done", n);
        @(posedge clk_in);
    endtask

    // Keys sent: 0 none, 1 first only, 2 both
    task automatic ctl(logic [31:0] d, int k);
        if (k > 0) acc(1'b1, osc_pkg::OSC_UNLOCK_ADDR, osc_pkg::UNLOCK_KEY_ONE);
        if (k > 1) acc(1'b1, osc_pkg::OSC_UNLOCK_ADDR, osc_pkg::UNLOCK_KEY_TWO);
        acc(1'b1, osc_pkg::OSC_CTRL_ADDR, d);
        wr_in <= 1'b0;
        @(posedge clk_in);
        if (k > 1) begin
            slp = d[4];
            if (!(lock[0] && switch_monitor_cfg_in[1])) begin
                mult = d[18:16];
                div  = d[26:24];
                req  = d[10:8];
                lock = d[7];
            end
        end
    endtask

    task automatic rst(logic [2:0] c);
        @(posedge clk_in);
        reset_in             <= 1'b1;
        cfg_source_select_in <= c;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        mult = 0;
        div  = 0;
        lock = 0;
        slp  = 0;
        req = c;
        cur = c;
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h3aa7));
        rst(3'h2);
        look("reset");
        for (i = 0; i < 8; i++) begin
            ctl(($urandom & 32'hfff8_ff7e) | (i << 16), 2);
            look("multiplier");
        end
        ctl(32'h0700_0300, 0);
        look("no unlock");
        ctl(32'h0600_0500, 1);
        look("broken unlock");
        @(posedge clk_in);
        switch_monitor_cfg_in <= 2'h2;
        ctl(32'h0000_0080, 2);
        ctl(32'h0005_0610, 2);
        look("frozen");
        ctl(32'h0000_0000, 2);
        look("still frozen");
        @(posedge clk_in);
        switch_monitor_cfg_in <= 2'h0;
        ctl(32'h0003_0590, 2);
        look("lock ignored");
        ctl(32'h0002_0400, 2);
        look("lock cleared");
        for (i = 0; i < 4; i++) begin
            @(posedge clk_in);
            usb_pll_lock_in <= i[0];
            sys_pll_lock_in <= i[1];
            repeat (4) @(posedge clk_in);
            look("pll status");
        end
        ctl(32'h0000_0001 | (((cur + 3) % 8) << 8), 2);
        chk("source held", 32'(active_source_out), 32'(cur));
        repeat (12) @(posedge clk_in);
        cur = req;
        look("switched");
        rd_at(8'h10);
        chk("unmapped", rdata_out, 32'h0);
        rst(3'h6);
        look("reset again");
        report_and_stop();
    end

    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
endmodule
